// ### src/gsmc_top.sv
// Genset mode controller: mode buttons, engine sequencing, changeover and alarms.
`timescale 1ns/1ns
module gsmc_top import gsmc_pkg::*; #(
   parameter bit HAS_MAINS = 1'h1, // Variant with mains switching.
   parameter int ALM_N = 8, // Number of alarm inputs, at most 16.
   parameter int REQ_N = 4, // Number of start request sources.
   parameter logic [19:0] DEB_CNT = 20'(DEB_CYC), // Debounce length in cycles.
   parameter logic [31:0] RETD_DFLT = 32'(RETD_CYC), // Return delay reset value.
   parameter logic [31:0] COOL_DFLT = 32'(COOL_CYC) // Cooling time reset value.
) (
   input wire logic SYS_CLK, // System clock.
   input wire logic NRST, // Asynchronous reset, active low.
   input wire logic CE, // Clock enable, freezes all state when low.
   input wire gsmc_btn_t BTN, // Raw front-panel buttons, high when pressed.
   input wire logic DIN_TO_GEN, // Digital input to_gen_transfer_cmd.
   input wire logic DIN_TO_UTIL, // Digital input to_utility_transfer_cmd.
   input wire logic DIN_ON_LOAD, // Digital input on-load request.
   input wire logic [REQ_N-1:0] START_REQ, // Automatic start requests.
   input wire logic ENG_RUNNING, // Engine is running.
   input wire logic GEN_AVAIL, // Generator output is available.
   input wire logic [ALM_N-1:0] ALARM_COND, // Live alarm conditions.
   output gsmc_out_t OUT, // Engine and changeover outputs.
   output logic [ALM_N-1:0] LAMPS, // Front indicator lamps.
   output logic [1:0] MODE, // Current operating mode.
   input wire logic [AXI_AW-1:0] S_AXI_AWADDR, // Write address.
   input wire logic S_AXI_AWVALID, // Write address valid.
   output logic S_AXI_AWREADY, // Write address ready.
   input wire logic [31:0] S_AXI_WDATA, // Write data.
   input wire logic [3:0] S_AXI_WSTRB, // Write byte strobes.
   input wire logic S_AXI_WVALID, // Write data valid.
   output logic S_AXI_WREADY, // Write data ready.
   output logic [1:0] S_AXI_BRESP, // Write response.
   output logic S_AXI_BVALID, // Write response valid.
   input wire logic S_AXI_BREADY, // Write response ready.
   input wire logic [AXI_AW-1:0] S_AXI_ARADDR, // Read address.
   input wire logic S_AXI_ARVALID, // Read address valid.
   output logic S_AXI_ARREADY, // Read address ready.
   output logic [31:0] S_AXI_RDATA, // Read data.
   output logic [1:0] S_AXI_RRESP, // Read response.
   output logic S_AXI_RVALID, // Read data valid.
   input wire logic S_AXI_RREADY // Read data ready.
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [7:0] raw, stable_q, rise_q;
   logic [19:0] cnt_q [8];
   gsmc_btn_t pls;
   gsmc_mode_t mode_q;
   gsmc_eng_t eng_q, eng_d;
   logic run_cmd_q, ecu_req_q, tgt_gen_q, gen_close_q, util_close_q;
   logic fuel_q, crank_q, ecu_q, sounder_q, audible_q;
   logic [ALM_N-1:0] alarm_q, lamps_q, new_alm;
   logic [31:0] ctrl_q, retd_q, cool_q, tmr_q;
   logic req, run_want, din_en, cmd_gen, cmd_util;
   logic aw_q, w_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_q, rdata_q, stat;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      return a == OFS_CTRL || a == OFS_RETD || a == OFS_COOL || a == OFS_STAT;
   endfunction : mapped

   // ----------------------------------------------------------------
   // Button debounce
   // ----------------------------------------------------------------
   // A level must hold for DEB_CNT cycles; contact chatter never makes two pulses.
   assign raw = BTN;
   assign pls = gsmc_btn_t'(rise_q);
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         stable_q <= 8'h00;
         rise_q <= 8'h00;
         for (int i = 0; i < 8; i++) cnt_q[i] <= 20'h0_0000;
      end else if (CE) begin
         for (int i = 0; i < 8; i++) begin
            rise_q[i] <= 1'h0;
            if (raw[i] == stable_q[i]) begin
               cnt_q[i] <= 20'h0_0000;
            end else if (cnt_q[i] >= DEB_CNT - 20'h0_0001) begin
               cnt_q[i] <= 20'h0_0000;
               stable_q[i] <= raw[i];
               rise_q[i] <= raw[i];
            end else begin
               cnt_q[i] <= cnt_q[i] + 20'h0_0001;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Operating mode
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         mode_q <= MD_STOP;
      end else if (CE) begin
         if (pls.stop_b) mode_q <= MD_STOP;
         else if (pls.man_b) mode_q <= MD_MAN;
         else if (pls.test_b && HAS_MAINS) mode_q <= MD_TEST;
         else if (pls.auto_b) mode_q <= MD_AUTO;
      end
   end

   // Start button latches a run command in manual and test only.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         run_cmd_q <= 1'h0;
         ecu_req_q <= 1'h0;
      end else if (CE) begin
         if (pls.stop_b || pls.man_b || pls.test_b || pls.auto_b) begin
            run_cmd_q <= 1'h0;
            ecu_req_q <= 1'h0;
         end else if (pls.start_b) begin
            if (mode_q == MD_MAN || mode_q == MD_TEST) run_cmd_q <= 1'h1;
            if (mode_q == MD_STOP) ecu_req_q <= 1'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Engine sequence
   // ----------------------------------------------------------------
   assign req = |START_REQ;
   assign run_want = (mode_q == MD_AUTO) ? req : run_cmd_q;

   always_comb begin
      eng_d = eng_q;
      case (eng_q)
         ST_REST: if (run_want) eng_d = ST_CRANK;
         ST_CRANK: begin
            if (!run_want) eng_d = ST_REST;
            else if (ENG_RUNNING) eng_d = ST_RUN;
         end
         ST_RUN: begin
            if (!ENG_RUNNING) eng_d = ST_REST;
            else if (!run_want) begin
               if (mode_q != MD_AUTO) eng_d = ST_REST;
               else eng_d = gen_close_q ? ST_RETD : ST_COOL;
            end
         end
         ST_RETD, ST_COOL: begin
            if (run_want) eng_d = ST_RUN;
            else if (mode_q != MD_AUTO) eng_d = ST_REST;
            else if (tmr_q == 32'h0) eng_d = (eng_q == ST_RETD) ? ST_COOL : ST_REST;
         end
         default: eng_d = ST_REST;
      endcase
      if (mode_q == MD_STOP) eng_d = ST_REST;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         eng_q <= ST_REST;
         fuel_q <= 1'h0;
         crank_q <= 1'h0;
         ecu_q <= 1'h0;
      end else if (CE) begin
         eng_q <= eng_d;
         fuel_q <= eng_d != ST_REST;
         crank_q <= eng_d == ST_CRANK;
         ecu_q <= ecu_req_q || eng_d != ST_REST;
      end
   end

   // One counter serves both delays because they never overlap.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         tmr_q <= 32'h0;
      end else if (CE) begin
         if (eng_d == ST_RETD && eng_q != ST_RETD) tmr_q <= retd_q;
         else if (eng_d == ST_COOL && eng_q != ST_COOL) tmr_q <= cool_q;
         else if (tmr_q != 32'h0) tmr_q <= tmr_q - 32'h1;
      end
   end

   // ----------------------------------------------------------------
   // Changeover
   // ----------------------------------------------------------------
   assign din_en = ctrl_q[CTRL_DIN_EN];
   assign cmd_gen = pls.to_gen_transfer_cmd || (din_en && DIN_TO_GEN);
   assign cmd_util = pls.to_utility_transfer_cmd || (din_en && DIN_TO_UTIL);

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         tgt_gen_q <= 1'h0;
      end else if (CE) begin
         if (mode_q == MD_STOP || eng_q == ST_REST || eng_q == ST_CRANK) begin
            tgt_gen_q <= 1'h0;
         end else if (eng_q == ST_RETD && tmr_q == 32'h0) begin
            tgt_gen_q <= 1'h0;
         end else if (mode_q == MD_MAN) begin
            if (cmd_util) tgt_gen_q <= 1'h0;
            else if (cmd_gen && eng_q == ST_RUN && GEN_AVAIL) tgt_gen_q <= 1'h1;
            else if (din_en && DIN_ON_LOAD && eng_q == ST_RUN) tgt_gen_q <= 1'h1;
         end else if (eng_q == ST_RUN && GEN_AVAIL) begin
            tgt_gen_q <= 1'h1;
         end
      end
   end

   // Break before make: the closed side always opens a cycle before the other closes.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         gen_close_q <= 1'h0;
         util_close_q <= 1'h0;
      end else if (CE) begin
         if (tgt_gen_q) begin
            if (util_close_q) util_close_q <= 1'h0;
            else gen_close_q <= 1'h1;
         end else begin
            if (gen_close_q) gen_close_q <= 1'h0;
            else util_close_q <= HAS_MAINS;
         end
      end
   end

   // ----------------------------------------------------------------
   // Alarms, sounder and lamps
   // ----------------------------------------------------------------
   assign new_alm = ALARM_COND & ~alarm_q;
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         alarm_q <= '0;
         sounder_q <= 1'h0;
         audible_q <= 1'h0;
         lamps_q <= '0;
      end else if (CE) begin
         alarm_q <= (pls.stop_b ? (alarm_q & ALARM_COND) : alarm_q) | ALARM_COND;
         if (|new_alm) begin
            sounder_q <= 1'h1;
            audible_q <= ctrl_q[CTRL_AUD_EN];
         end else if (pls.mute_b) begin
            sounder_q <= 1'h0;
            audible_q <= 1'h0;
         end
         lamps_q <= stable_q[2] ? '1 : alarm_q;
      end
   end

   assign OUT = '{fuel: fuel_q, crank: crank_q, engine_control_unit: ecu_q,
                  gen_close: gen_close_q, util_close: util_close_q,
                  sounder: sounder_q, audible: audible_q};
   assign LAMPS = lamps_q;
   assign MODE = mode_q;

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   always_comb begin
      stat = 32'h0;
      stat[STAT_MODE +: 2] = mode_q;
      stat[STAT_ENG +: 3] = eng_q;
      stat[STAT_GEN] = gen_close_q;
      stat[STAT_UTIL] = util_close_q;
      stat[STAT_SND] = sounder_q;
      stat[STAT_ALM +: ALM_N] = alarm_q;
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         aw_q <= 1'h0;
         w_q <= 1'h0;
         awready_q <= 1'h1;
         wready_q <= 1'h1;
         bvalid_q <= 1'h0;
         bresp_q <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         ctrl_q <= CTRL_RST;
         retd_q <= RETD_DFLT;
         cool_q <= COOL_DFLT;
      end else if (CE) begin
         if (S_AXI_AWVALID && awready_q) begin
            aw_q <= 1'h1;
            awaddr_q <= S_AXI_AWADDR;
            awready_q <= 1'h0;
         end
         if (S_AXI_WVALID && wready_q) begin
            w_q <= 1'h1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
            wready_q <= 1'h0;
         end
         if (aw_q && w_q && !bvalid_q) begin
            aw_q <= 1'h0;
            w_q <= 1'h0;
            bvalid_q <= 1'h1;
            bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
            if (awaddr_q == OFS_CTRL) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h3;
            if (awaddr_q == OFS_RETD) retd_q <= merge(retd_q, wdata_q, wstrb_q);
            if (awaddr_q == OFS_COOL) cool_q <= merge(cool_q, wdata_q, wstrb_q);
         end
         if (bvalid_q && S_AXI_BREADY) begin
            bvalid_q <= 1'h0;
            awready_q <= 1'h1;
            wready_q <= 1'h1;
         end
      end
   end

   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST) begin
         arready_q <= 1'h1;
         rvalid_q <= 1'h0;
         rdata_q <= 32'h0;
         rresp_q <= RESP_OKAY;
      end else if (CE) begin
         if (S_AXI_ARVALID && arready_q) begin
            arready_q <= 1'h0;
            rvalid_q <= 1'h1;
            rresp_q <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
            case (S_AXI_ARADDR)
               OFS_CTRL: rdata_q <= ctrl_q;
               OFS_RETD: rdata_q <= retd_q;
               OFS_COOL: rdata_q <= cool_q;
               OFS_STAT: rdata_q <= stat;
               default: rdata_q <= 32'h0;
            endcase
         end
         if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'h0;
            arready_q <= 1'h1;
         end
      end
   end

   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = arready_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   load_exclusive_a: assert property (!(gen_close_q && util_close_q))
      else $error("Both load switches closed.");
   gen_make_a: assert property ($rose(gen_close_q) |-> $past(!util_close_q))
      else $error("Generator closed while mains was closed.");
   stop_fuel_a: assert property (CE && mode_q == MD_STOP |=> !fuel_q && eng_q == ST_REST)
      else $error("Fuel on in stop mode.");
   stop_ignore_a: assert property (mode_q == MD_STOP && req [*3] |-> !crank_q)
      else $error("Engine cranked in stop mode.");
   alarm_clear_a: assert property (CE && pls.stop_b |=> alarm_q == $past(ALARM_COND))
      else $error("Stale alarm kept after stop.");
   mute_sound_a: assert property (CE && pls.mute_b && new_alm == '0 |=> !sounder_q && !audible_q)
      else $error("Sounder still on after mute.");
   lamp_test_a: assert property (CE && stable_q[2] |=> lamps_q == {ALM_N{1'h1}})
      else $error("Lamp test incomplete.");
   ecu_prime_a: assert property (CE && mode_q == MD_STOP && pls.start_b ##1 CE |=> ecu_q && !crank_q)
      else $error("Engine unit not powered by stop start.");
   auto_start_a: assert property (CE && mode_q == MD_AUTO && eng_q == ST_REST && req |=> eng_q == ST_CRANK)
      else $error("Auto mode missed a start request.");
   pulse_once_a: assert property (rise_q[3] |=> !rise_q[3])
      else $error("Start pulse longer than one cycle.");

   auto_load_c: cover property (mode_q == MD_AUTO && $rose(gen_close_q));
   cool_stop_c: cover property (eng_q == ST_COOL ##1 eng_q == ST_REST);
   man_transfer_c: cover property (mode_q == MD_MAN && $fell(util_close_q));
endmodule : gsmc_top

// ### src/gsmc_pkg.sv
// Shared constants, types and register map for the genset mode controller.
package gsmc_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int AXI_AW = 4;
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_RETD = 4'h4;
   localparam logic [3:0] OFS_COOL = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hc;
   localparam int CTRL_DIN_EN = 0;
   localparam int CTRL_AUD_EN = 1;
   localparam logic [31:0] CTRL_RST = 32'h0000_0003;
   localparam int STAT_MODE = 0;
   localparam int STAT_ENG = 2;
   localparam int STAT_GEN = 5;
   localparam int STAT_UTIL = 6;
   localparam int STAT_SND = 7;
   localparam int STAT_ALM = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint CLK_HZ = 100_000_000;
   localparam longint DEB_MS = 10;
   localparam longint RETD_S = 10;
   localparam longint COOL_S = 20;
   localparam longint DEB_CYC = DEB_MS * CLK_HZ / 1000;
   localparam longint RETD_CYC = RETD_S * CLK_HZ;
   localparam longint COOL_CYC = COOL_S * CLK_HZ;
   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MD_STOP = 2'h0, MD_MAN = 2'h1, MD_TEST = 2'h2, MD_AUTO = 2'h3
   } gsmc_mode_t;
   typedef enum logic [2:0] {
      ST_REST = 3'h0, ST_CRANK = 3'h1, ST_RUN = 3'h2, ST_RETD = 3'h3, ST_COOL = 3'h4
   } gsmc_eng_t;
   typedef struct packed {
      logic stop_b;
      logic man_b;
      logic test_b;
      logic auto_b;
      logic start_b;
      logic mute_b;
      logic to_gen_transfer_cmd;
      logic to_utility_transfer_cmd;
   } gsmc_btn_t;
   typedef struct packed {
      logic fuel;
      logic crank;
      logic engine_control_unit;
      logic gen_close;
      logic util_close;
      logic sounder;
      logic audible;
   } gsmc_out_t;
endpackage : gsmc_pkg

// ### dv/gsmc_plant.sv
// Engine and generator plant model that answers the controller outputs.
`timescale 1ns/1ns
module gsmc_plant import gsmc_pkg::*; #(
   parameter int START_CYC = 3 // Cranking cycles before the engine fires.
) (
   input wire logic SYS_CLK, // Clock.
   input wire logic NRST, // Reset, active low.
   input wire logic SLOW, // Makes cranking take four times longer.
   input wire gsmc_out_t OUT, // Controller outputs.
   output logic ENG_RUNNING, // Engine running.
   output logic GEN_AVAIL // Generator available.
);
   int cnt_q;
   // The engine dies at once without fuel, so a missed fuel cut shows up as a running set.
   always_ff @(posedge SYS_CLK or negedge NRST) begin
      if (!NRST || !OUT.fuel) begin
         cnt_q <= 0;
         ENG_RUNNING <= 1'h0;
         GEN_AVAIL <= 1'h0;
      end else begin
         if (OUT.crank && !ENG_RUNNING) begin
            cnt_q <= cnt_q + 1;
         end
         if (cnt_q >= (SLOW ? 4 * START_CYC : START_CYC)) begin
            ENG_RUNNING <= 1'h1;
         end
         GEN_AVAIL <= ENG_RUNNING;
      end
   end
endmodule : gsmc_plant

// ### dv/genset_mode_controller_test.sv
// Self-checking bench for the genset mode controller.
`timescale 1ns/1ns
module genset_mode_controller_test import gsmc_pkg::*;;
   localparam int DEB = 4;
   logic clk = 1'h0;
   logic nrst = 1'h0;
   logic slow = 1'h0;
   logic ce = 1'h1;
   logic [3:0] wstrb = 4'hf;
   gsmc_btn_t btn = 8'h0;
   logic din_g = 1'h0, din_u = 1'h0, din_l = 1'h0;
   logic [3:0] req = 4'h0, awaddr = 4'h0, araddr = 4'h0;
   logic [7:0] alm = 8'h0, lat, seed = 8'h38, lamps;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, run, avail;
   logic [1:0] bresp, rresp, mode;
   gsmc_out_t out;
   int n_fail = 0, tests_run = 0, j;
   wire logic [8:0] obs = {avail, run, out};

   always #5 clk = ~clk;

   gsmc_top #(.DEB_CNT(20'h4), .RETD_DFLT(32'h14), .COOL_DFLT(32'h1e)) gsmc_top_inst (
      .SYS_CLK(clk), .NRST(nrst), .CE(ce), .BTN(btn), .DIN_TO_GEN(din_g),
      .DIN_TO_UTIL(din_u), .DIN_ON_LOAD(din_l), .START_REQ(req), .ENG_RUNNING(run),
      .GEN_AVAIL(avail), .ALARM_COND(alm), .OUT(out), .LAMPS(lamps), .MODE(mode),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

   gsmc_plant gsmc_plant_inst (.SYS_CLK(clk), .NRST(nrst), .SLOW(slow), .OUT(out),
      .ENG_RUNNING(run), .GEN_AVAIL(avail));

   // ----------------------------------------------------------------
   // Tasks and expectations
   // ----------------------------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   function automatic logic [7:0] exp_lamps(input logic [7:0] l, input logic [7:0] c);
      return l & c;
   endfunction : exp_lamps

   task report_and_stop;
      $display("checks %0d errors %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : report_and_stop

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wait_obs(input int k, input logic v, input int n);
      int i;
      for (i = 0; i < n && obs[k] !== v; i++) @(negedge clk);
      chk(32'(obs[k]), 32'(v));
      if (i == n) report_and_stop();
   endtask : wait_obs

   // The level is held long enough for the debouncer, then effects settle.
   task btn_set(input int k, input logic v);
      @(posedge clk);
      btn[k] <= v;
      repeat (DEB + 6) @(posedge clk);
      @(negedge clk);
   endtask : btn_set

   task press(input int k);
      btn_set(k, 1'h1);
      btn_set(k, 1'h0);
   endtask : press

   task axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      chk(32'(bresp), 32'(er));
      if (i == 40) report_and_stop();
   endtask : axi_wr

   task axi_rd(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
      int i;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 40; i++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      d = rdata;
      chk(32'(rresp), 32'(er));
      if (i == 40) report_and_stop();
   endtask : axi_rd

   always @(negedge clk) if (nrst) chk(32'(out.gen_close & out.util_close), 32'h0);

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'h1;
      repeat (2) @(negedge clk);
      chk(32'(mode), 32'(MD_STOP));
      chk(32'(out), 32'h4);
      axi_rd(OFS_CTRL, rd, RESP_OKAY);
      chk(rd, CTRL_RST);
      axi_rd(OFS_RETD, rd, RESP_OKAY);
      chk(rd, 32'h14);
      axi_rd(OFS_STAT, rd, RESP_OKAY);
      chk(rd, 32'h40);
      @(posedge clk);
      wstrb <= 4'h1;
      axi_wr(OFS_RETD, 32'haaaa_aa07, RESP_OKAY);
      axi_rd(OFS_RETD, rd, RESP_OKAY);
      chk(rd, 32'h7);
      @(posedge clk);
      wstrb <= 4'hf;
      axi_wr(OFS_RETD, 32'h14, RESP_OKAY);
      axi_wr(OFS_CTRL, 32'hffff_ffff, RESP_OKAY);
      axi_rd(OFS_CTRL, rd, RESP_OKAY);
      chk(rd, 32'h3);
      axi_wr(4'h1, 32'h0, RESP_SLVERR);
      axi_rd(4'h2, rd, RESP_SLVERR);
      axi_wr(OFS_STAT, 32'h0, RESP_OKAY);
      seed = lfsr(seed);
      lat = seed | 8'h10;
      @(posedge clk);
      alm <= lat;
      wait_obs(1, 1'h1, 10);
      chk(32'(out.audible), 32'h1);
      btn_set(2, 1'h1);
      chk(32'(lamps), 32'hff);
      chk(32'({out.sounder, out.audible}), 32'h0);
      btn_set(2, 1'h0);
      @(posedge clk);
      alm <= lat & 8'h0f;
      press(7);
      chk(32'(lamps), 32'(exp_lamps(lat, lat & 8'h0f)));
      @(posedge clk);
      alm <= 8'h0;
      req <= 4'hf;
      press(3);
      chk(32'(out.engine_control_unit), 32'h1);
      chk(32'({out.fuel, out.crank}), 32'h0);
      @(posedge clk);
      req <= 4'h0;
      press(6);
      chk(32'(mode), 32'(MD_MAN));
      press(3);
      wait_obs(8, 1'h1, 40);
      repeat (6) @(negedge clk);
      chk(32'({out.gen_close, out.util_close}), 32'h1);
      press(1);
      chk(32'({out.gen_close, out.util_close}), 32'h2);
      press(0);
      chk(32'({out.gen_close, out.util_close}), 32'h1);
      @(posedge clk);
      din_g <= 1'h1;
      wait_obs(3, 1'h1, 12);
      @(posedge clk);
      din_g <= 1'h0;
      din_u <= 1'h1;
      wait_obs(2, 1'h1, 12);
      @(posedge clk);
      din_u <= 1'h0;
      din_l <= 1'h1;
      wait_obs(3, 1'h1, 12);
      @(posedge clk);
      din_l <= 1'h0;
      repeat (10) @(negedge clk);
      chk(32'(out.gen_close), 32'h1);
      press(7);
      chk(32'({out.gen_close, out.util_close}), 32'h1);
      chk(32'(out.fuel), 32'h0);
      @(posedge clk);
      slow <= 1'h1;
      press(5);
      chk(32'(mode), 32'(MD_TEST));
      press(3);
      wait_obs(3, 1'h1, 80);
      @(posedge clk);
      slow <= 1'h0;
      press(7);
      press(4);
      chk(32'(mode), 32'(MD_AUTO));
      press(3);
      chk(32'(out.fuel), 32'h0);
      // A press while the clock enable is low must leave the mode unchanged.
      @(posedge clk);
      ce <= 1'h0;
      press(6);
      @(posedge clk);
      ce <= 1'h1;
      @(negedge clk);
      chk(32'(mode), 32'(MD_AUTO));
      for (j = 0; j < 2; j++) begin
         seed = lfsr(seed);
         @(posedge clk);
         req <= seed[3:0] | 4'h1;
         wait_obs(3, 1'h1, 60);
         chk(32'(out.util_close), 32'h0);
         @(posedge clk);
         req <= 4'h0;
         repeat (15) @(negedge clk);
         chk(32'(out.gen_close), 32'h1);
         wait_obs(2, 1'h1, 30);
         repeat (20) @(negedge clk);
         chk(32'(out.fuel), 32'h1);
         wait_obs(6, 1'h0, 30);
      end
      report_and_stop();
   end
endmodule : genset_mode_controller_test
